// File: rtl/spc_dev_end.sv
/*
 Protection end: decodes enable and disable frames, filters
 write-protect, holds the sector table and judges program or
 erase requests. Assumes link pins are asynchronous to CLK_SYS.
*/
`timescale 1ns/1ps
`default_nettype none
module spc_dev_end
	import spc_pkg::*;
#(
	parameter int WPE_CYC = WPE_DELAY_CYC,
	parameter int WPD_CYC = WPD_DELAY_CYC
)(
	input wire logic CLK_SYS,
	input wire logic RST_N,
	input wire logic CE,
	spc_link_if.dev LINK,
	input wire logic PE_REQ,
	input wire logic PE_TABLE,
	input wire logic [3:0] PE_SECTOR,
	input wire logic PE_SUB,
	input wire logic [7:0] PE_DATA,
	output logic PE_DONE,
	output logic PE_OK,
	output logic PROT_ACTIVE,
	output logic SW_PROT,
	output logic WP_PROT
);

	// Filter lengths leave room for the pin synchroniser
	localparam int WPE_FILT = WPE_CYC - PIN_SYNC_CYC;
	localparam int WPD_FILT = WPD_CYC - PIN_SYNC_CYC;

	if (WPE_CYC < 2 * PIN_SYNC_CYC || WPD_CYC < 2 * PIN_SYNC_CYC || WPE_CYC > 65535 || WPD_CYC > 65535)
	begin : g_chk
		$error("spc_dev_end: write-protect delays out of range");
	end

	logic [3:0] pin_raw;
	logic [3:0] s1_q;
	logic [3:0] s2_q;
	logic [3:0] s3_q;
	logic [3:0] filt_q;
	logic [3:0] filt_d;
	logic sck_rise;
	logic cs_rise;
	logic cs_fall;
	logic [CMD_BITS-1:0] shift_q;
	logic [5:0] nbits_q;
	logic frame_ok;
	logic wp_pin_act;
	logic [15:0] wp_cnt_q;
	logic wp_prot_q;
	logic sw_en_q;
	logic prot_d;
	logic [7:0] table_q [SECTOR_COUNT];

	assign pin_raw = {LINK.wp_n, LINK.mosi, LINK.cs_n, LINK.sck};

	////////////////////////////////////////////////////////////////
	// Pin synchronisers

	// Three stages per pin
	always_ff @(posedge CLK_SYS)
	begin
		if (!RST_N)
		begin
			s1_q <= PIN_IDLE;
			s2_q <= PIN_IDLE;
			s3_q <= PIN_IDLE;
			filt_q <= PIN_IDLE;
		end
		else if (CE)
		begin
			s1_q <= pin_raw;
			s2_q <= s1_q;
			s3_q <= s2_q;
			filt_q <= filt_d;
		end
	end

	// Accept a level once stages two and three agree
	assign filt_d = (s2_q & ~(s2_q ^ s3_q)) | (filt_q & (s2_q ^ s3_q));
	assign sck_rise = filt_d[PIN_SCK] & ~filt_q[PIN_SCK];
	assign cs_rise = filt_d[PIN_CS] & ~filt_q[PIN_CS];
	assign cs_fall = ~filt_d[PIN_CS] & filt_q[PIN_CS];
	assign wp_pin_act = ~filt_q[PIN_WP];

	////////////////////////////////////////////////////////////////
	// Command frame capture

	// Shift in on clock rise while selected
	always_ff @(posedge CLK_SYS)
	begin
		if (!RST_N)
		begin
			shift_q <= '0;
			nbits_q <= '0;
		end
		else if (CE)
		begin
			if (cs_fall)
				nbits_q <= '0;
			else if (sck_rise && !filt_q[PIN_CS])
			begin
				shift_q <= {shift_q[CMD_BITS-2:0], filt_q[PIN_MOSI]};
				if (nbits_q <= 6'(CMD_BITS))
					nbits_q <= nbits_q + 6'd1; // Saturates past a full frame
			end
		end
	end

	// Exactly four bytes with the shared prefix
	assign frame_ok = (nbits_q == 6'(CMD_BITS)) && (shift_q[31:8] == OP_PREFIX);

	////////////////////////////////////////////////////////////////
	// Software protection state

	// Power-up and reset start unprotected
	always_ff @(posedge CLK_SYS)
	begin
		if (!RST_N)
			sw_en_q <= 1'b0; // [R4]
		else if (CE && cs_rise && frame_ok)
		begin
			if (shift_q[7:0] == OP_PROT_ON)
				sw_en_q <= 1'b1; // [R6] [R7] [R15]
			else if (shift_q[7:0] == OP_PROT_OFF && !wp_prot_q)
				sw_en_q <= 1'b0; // [R8] [R9] [R16]
			// Other fourth bytes fall through unchanged [R19]
		end
	end

	////////////////////////////////////////////////////////////////
	// Write-protect filter

	// Level must persist for the filter span before it counts
	always_ff @(posedge CLK_SYS)
	begin
		if (!RST_N)
		begin
			wp_prot_q <= 1'b0;
			wp_cnt_q <= '0;
		end
		else if (CE)
		begin
			if (wp_pin_act == wp_prot_q)
				wp_cnt_q <= '0; // [R17]
			else if (wp_cnt_q == 16'(wp_prot_q ? WPD_FILT - 1 : WPE_FILT - 1))
			begin
				wp_prot_q <= wp_pin_act; // [R13] [R14]
				wp_cnt_q <= '0;
			end
			else
				wp_cnt_q <= wp_cnt_q + 16'd1;
		end
	end

	////////////////////////////////////////////////////////////////
	// Status outputs

	// Either cause puts protection in force
	assign prot_d = sw_en_q | wp_prot_q; // [R12] [R14]

	always_ff @(posedge CLK_SYS)
	begin
		if (!RST_N)
		begin
			PROT_ACTIVE <= 1'b0;
			SW_PROT <= 1'b0;
			WP_PROT <= 1'b0;
		end
		else if (CE)
		begin
			PROT_ACTIVE <= prot_d; // [R2]
			SW_PROT <= sw_en_q;
			WP_PROT <= wp_prot_q;
		end
	end

	////////////////////////////////////////////////////////////////
	// Protection table and request judge

	// Table is nonvolatile: no reset
	always_ff @(posedge CLK_SYS)
	begin
		if (CE && PE_REQ && PE_TABLE && !wp_prot_q)
			table_q[PE_SECTOR] <= PE_DATA; // [R11] [R18]
	end

	// Answer every request one cycle later
	always_ff @(posedge CLK_SYS)
	begin
		if (!RST_N)
		begin
			PE_DONE <= 1'b0;
			PE_OK <= 1'b0;
		end
		else if (CE)
		begin
			PE_DONE <= PE_REQ;
			if (!PE_REQ)
				PE_OK <= 1'b0;
			else if (PE_TABLE)
				PE_OK <= !wp_prot_q; // [R10] [R11]
			else
				PE_OK <= !(prot_d && spc_guarded(table_q[PE_SECTOR], PE_SECTOR, PE_SUB)); // [R1] [R10]
		end
	end

endmodule // spc_dev_end
`default_nettype wire

// File: rtl/spc_pkg.sv
/*
 Shared constants for the sector protection control link: opcodes,
 pin reset levels, timing counts and the sector guard decode.
 Assumes a single 40 MHz system clock shared by both ends.
*/
// Operation
// [R1] Guard sectors from table only while protection on
// [R2] Report protection in force, either cause
// [R3] Undriven write-protect input reads as deasserted
// [R4] Power-up clears software protection state
// [R5] Host without write-protect resends enable after power-up
// [R6] 3Dh 2Ah 7Fh A9h turns protection on
// [R7] Enable takes effect on chip select rising
// [R8] 3Dh 2Ah 7Fh 9Ah turns protection off
// [R9] Disable takes effect on chip select rising
// [R10] Write-protect refuses guarded sectors and table
// [R11] Table changes only while write-protect deasserted
// [R12] Write-protect overrides software only for guarding
// [R13] Write-protect assertion protects within enable delay
// [R14] Release unprotects within delay unless enabled
// [R15] Enable before or during write-protect persists
// [R16] Disable ignored while write-protect asserted
// [R17] Glitches on write-protect are filtered out
// [R18] Table holds one byte per sector 0-15
// [R19] Unknown fourth byte leaves protection unchanged
package spc_pkg;

	// Command bytes
	localparam logic [7:0] OP_PREFIX_0 = 8'h3D;
	localparam logic [7:0] OP_PREFIX_1 = 8'h2A;
	localparam logic [7:0] OP_PREFIX_2 = 8'h7F;
	localparam logic [7:0] OP_PROT_ON = 8'hA9;
	localparam logic [7:0] OP_PROT_OFF = 8'h9A;
	localparam logic [23:0] OP_PREFIX = {OP_PREFIX_0, OP_PREFIX_1, OP_PREFIX_2};

	// Frame and table shape
	localparam int CMD_BITS = 32;
	localparam int SECTOR_COUNT = 16;
	localparam logic [7:0] SECTOR_GUARD_BYTE = 8'hFF;
	localparam logic [1:0] SUB_GUARD_BITS = 2'h3;
	localparam int SUB_A_POS = 6;
	localparam int SUB_B_POS = 4;

	// Pin order {wp_n, mosi, cs_n, sck} and idle levels
	localparam logic [3:0] PIN_IDLE = 4'hA;
	localparam int PIN_SCK = 0;
	localparam int PIN_CS = 1;
	localparam int PIN_MOSI = 2;
	localparam int PIN_WP = 3;
	localparam int PIN_SYNC_CYC = 4;

	// Timing
	localparam int CLK_PERIOD_NS = 25;
	localparam int WP_ASSERT_ENABLE_DELAY_NS = 500;
	localparam int WP_RELEASE_DISABLE_DELAY_NS = 500;
	localparam int WPE_DELAY_CYC = WP_ASSERT_ENABLE_DELAY_NS / CLK_PERIOD_NS;
	localparam int WPD_DELAY_CYC = WP_RELEASE_DISABLE_DELAY_NS / CLK_PERIOD_NS;
	localparam int SCK_HALF_CYC = 4;

	// Sector guard decode from one table byte
	function automatic logic spc_guarded(input logic [7:0] b, input logic [3:0] s, input logic sub);
		if (s == 4'h0)
			return sub ? (b[SUB_B_POS +: 2] == SUB_GUARD_BITS) : (b[SUB_A_POS +: 2] == SUB_GUARD_BITS);
		return b == SECTOR_GUARD_BYTE;
	endfunction

endpackage

// File: rtl/spc_link_if.sv
/*
 Serial link between the host end and the protection end.
 Assumes the testbench joins both ends; the write-protect line
 has a pull-up resolved here.
*/
`timescale 1ns/1ps
`default_nettype none
interface spc_link_if;
	logic sck;
	logic cs_n;
	logic mosi;
	logic wp_n_o;
	logic wp_n_oe;
	logic wp_n;

	// Pull-up on write-protect when nobody drives it
	assign wp_n = wp_n_oe ? wp_n_o : 1'b1; // [R3]

	modport dev (input sck, input cs_n, input mosi, input wp_n);
	modport host (output sck, output cs_n, output mosi, output wp_n_o, output wp_n_oe);
endinterface
`default_nettype wire

// File: rtl/spc_host_end.sv
/*
 Host end: sends a four-byte protection frame in SPI mode 0 and
 drives or releases write-protect. Assumes user requests come
 from logic on CLK_SYS.
*/
`timescale 1ns/1ps
`default_nettype none
module spc_host_end
	import spc_pkg::*;
#(
	parameter int HALF_CYC = SCK_HALF_CYC
)(
	input wire logic CLK_SYS,
	input wire logic RST_N,
	input wire logic CE,
	spc_link_if.host LINK,
	input wire logic CMD_REQ,
	input wire logic [7:0] CMD_LAST,
	input wire logic WP_HOLD,
	output logic CMD_BUSY,
	output logic CMD_DONE
);

	if (HALF_CYC < PIN_SYNC_CYC || HALF_CYC > 255)
	begin : g_chk
		$error("spc_host_end: serial half period out of range");
	end

	typedef enum logic [2:0] {ST_IDLE, ST_LO, ST_HI, ST_END, ST_GAP} spc_hst_e;

	spc_hst_e st_q;
	logic [7:0] cnt_q;
	logic [4:0] bit_q;
	logic [CMD_BITS-1:0] word_q;
	logic tick;

	assign tick = (cnt_q == 8'(HALF_CYC - 1));

	////////////////////////////////////////////////////////////////
	// Frame sequencer

	// One bit per clock period, changed on the falling edge
	always_ff @(posedge CLK_SYS)
	begin
		if (!RST_N)
		begin
			st_q <= ST_IDLE;
			cnt_q <= '0;
			bit_q <= '0;
			word_q <= '0;
			LINK.sck <= 1'b0;
			LINK.cs_n <= 1'b1;
			LINK.mosi <= 1'b0;
			CMD_BUSY <= 1'b0;
			CMD_DONE <= 1'b0;
		end
		else if (CE)
		begin
			CMD_DONE <= 1'b0;
			cnt_q <= tick ? 8'd0 : cnt_q + 8'd1;
			case (st_q)
				ST_IDLE:
				begin
					cnt_q <= '0;
					if (CMD_REQ)
					begin
						word_q <= {OP_PREFIX, CMD_LAST}; // [R6] [R8]
						LINK.cs_n <= 1'b0;
						LINK.mosi <= OP_PREFIX_0[7];
						bit_q <= 5'd31;
						CMD_BUSY <= 1'b1;
						st_q <= ST_LO;
					end
				end
				ST_LO:
					if (tick)
					begin
						LINK.sck <= 1'b1;
						st_q <= ST_HI;
					end
				ST_HI:
					if (tick)
					begin
						LINK.sck <= 1'b0;
						if (bit_q == 5'd0)
							st_q <= ST_END;
						else
						begin
							bit_q <= bit_q - 5'd1;
							LINK.mosi <= word_q[bit_q - 5'd1];
							st_q <= ST_LO;
						end
					end
				ST_END:
					if (tick)
					begin
						LINK.cs_n <= 1'b1; // [R7] [R9]
						st_q <= ST_GAP;
					end
				ST_GAP:
					if (tick)
					begin
						CMD_BUSY <= 1'b0;
						CMD_DONE <= 1'b1;
						st_q <= ST_IDLE;
					end
				default:
					st_q <= ST_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////
	// Write-protect drive

	// Drive low while held, otherwise leave to the pull-up
	always_ff @(posedge CLK_SYS)
	begin
		if (!RST_N)
		begin
			LINK.wp_n_o <= 1'b1;
			LINK.wp_n_oe <= 1'b0; // [R5]
		end
		else if (CE)
		begin
			LINK.wp_n_o <= 1'b0;
			LINK.wp_n_oe <= WP_HOLD;
		end
	end

endmodule // spc_host_end
`default_nettype wire

// File: verification/spc_link_properties.sv
/*
 Checker for the protection link and the verdict port.
 Assumes the bench instantiates it beside the link.
*/
`timescale 1ns/1ps
`default_nettype none
module spc_link_properties #(
	parameter int WPE_CYC = 20,
	parameter int WPD_CYC = 20
)(
	input wire logic CLK_SYS,
	input wire logic RST_N,
	input wire logic cs_n,
	input wire logic wp_n,
	input wire logic PE_REQ,
	input wire logic PE_TABLE,
	input wire logic PE_DONE,
	input wire logic PE_OK,
	input wire logic PROT_ACTIVE,
	input wire logic SW_PROT,
	input wire logic WP_PROT
);
	logic [5:0] low_q;
	logic [5:0] high_q;
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!RST_N);
	////////////////////////////////////////////////////////////
	// Run length of low write-protect
	always_ff @(posedge CLK_SYS)
	begin
		if (!RST_N || wp_n)
			low_q <= 6'h00;
		else if (low_q != 6'h3F)
			low_q <= low_q + 6'h01;
	end
	// Run length of high write-protect
	always_ff @(posedge CLK_SYS)
	begin
		if (!RST_N || !wp_n)
			high_q <= 6'h00;
		else if (high_q != 6'h3F)
			high_q <= high_q + 6'h01;
	end
	////////////////////////////////////////////////////////////
	sequence s_ans;
		##1 PE_DONE;
	endsequence
	sequence s_cs_up;
		cs_n && $past(cs_n, 4);
	endsequence
	pe_answer_a:
		assert property (PE_REQ |-> s_ans) else $error("no answer");
	pe_quiet_a:
		assert property (!$past(PE_REQ) |-> !PE_DONE && !PE_OK) else $error("stray answer");
	table_lock_a:
		assert property (PE_REQ && PE_TABLE |=> PE_OK != WP_PROT) else $error("table written");
	open_ok_a:
		assert property (PE_REQ ##1 (!SW_PROT && !WP_PROT) |-> PE_OK) else $error("refused");
	prot_on_a:
		assert property ((SW_PROT && $past(SW_PROT)) || (WP_PROT && $past(WP_PROT)) |-> PROT_ACTIVE)
		else $error("status low");
	prot_off_a:
		assert property (!SW_PROT && !WP_PROT && !$past(SW_PROT) && !$past(WP_PROT) |-> !PROT_ACTIVE)
		else $error("status high");
	sw_frame_a:
		assert property ($changed(SW_PROT) |-> s_cs_up) else $error("change off frame");
	dis_ignored_a:
		assert property ($fell(SW_PROT) |-> !$past(WP_PROT)) else $error("disable taken");
	wp_filter_a:
		assert property ($rose(WP_PROT) |-> low_q >= WPE_CYC - 4) else $error("early wp");
	wp_enable_a:
		assert property (low_q == WPE_CYC + 3 |-> WP_PROT) else $error("late wp");
	wp_release_a:
		assert property (high_q == WPD_CYC + 3 |-> !WP_PROT) else $error("late release");
endmodule // spc_link_properties
`default_nettype wire

// File: verification/sector_protection_control_tb.sv
/*
 Bench joining host and protection ends over one link.
 Assumes default delay parameters.
*/
`timescale 1ns/1ps
`default_nettype none
module sector_protection_control_tb;
	import spc_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic cmd_req = 1'b0;
	logic wp_hold = 1'b0;
	logic pe_req = 1'b0;
	logic pe_table = 1'b0;
	logic pe_sub = 1'b0;
	logic [7:0] cmd_last = 8'h00;
	logic [7:0] pe_data = 8'h00;
	logic [3:0] pe_sector = 4'h0;
	logic cmd_busy, cmd_done, pe_done, pe_ok, prot, sw, wpp;
	logic [31:0] shift_q = 32'h0000_0000;
	int err_count = 0;
	int total_checks = 0;
	int cyc = 0;
	spc_link_if link();
	spc_host_end spc_host_end_inst (.CLK_SYS(clk), .RST_N(rst_n), .CE(1'b1), .LINK(link), .CMD_REQ(cmd_req),
		.CMD_LAST(cmd_last), .WP_HOLD(wp_hold), .CMD_BUSY(cmd_busy), .CMD_DONE(cmd_done));
	spc_dev_end spc_dev_end_inst (.CLK_SYS(clk), .RST_N(rst_n), .CE(1'b1), .LINK(link), .PE_REQ(pe_req),
		.PE_TABLE(pe_table), .PE_SECTOR(pe_sector), .PE_SUB(pe_sub), .PE_DATA(pe_data), .PE_DONE(pe_done),
		.PE_OK(pe_ok), .PROT_ACTIVE(prot), .SW_PROT(sw), .WP_PROT(wpp));
	spc_link_properties #(.WPE_CYC(WPE_DELAY_CYC), .WPD_CYC(WPD_DELAY_CYC))
		spc_link_properties_inst (.CLK_SYS(clk), .RST_N(rst_n), .cs_n(link.cs_n),
		.wp_n(link.wp_n), .PE_REQ(pe_req), .PE_TABLE(pe_table), .PE_DONE(pe_done), .PE_OK(pe_ok),
		.PROT_ACTIVE(prot), .SW_PROT(sw), .WP_PROT(wpp));
	////////////////////////////////////////////////////////////
	// Clock and cycle ceiling
	initial forever #12.5 clk = ~clk;
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 10000)
		begin
			err_count++;
			test_done();
		end
	end
	// Wire capture at serial clock rise
	always @(posedge link.sck)
		if (!link.cs_n)
			shift_q <= {shift_q[30:0], link.mosi};
	////////////////////////////////////////////////////////////
	task automatic chk(input logic got, input logic exp, input string m);
		total_checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("[FAIL] %0t %s", $time, m);
		end
	endtask
	task automatic send(input logic [7:0] b);
		int n;
		@(posedge clk);
		cmd_last <= b;
		cmd_req <= 1'b1;
		@(posedge clk);
		cmd_req <= 1'b0;
		@(posedge clk);
		chk(cmd_busy, 1'b1, "not busy");
		n = 0;
		while (cmd_done !== 1'b1 && n < 400)
		begin
			@(posedge clk);
			n++;
		end
		chk(cmd_busy, 1'b0, "still busy");
		repeat (10) @(posedge clk);
		chk(shift_q === {OP_PREFIX, b}, 1'b1, "frame bits");
	endtask
	task automatic pe(input logic t, input logic [3:0] s, input logic u, input logic [7:0] d, input logic ok);
		@(posedge clk);
		pe_req <= 1'b1;
		pe_table <= t;
		pe_sector <= s;
		pe_sub <= u;
		pe_data <= d;
		@(posedge clk);
		pe_req <= 1'b0;
		@(posedge clk);
		chk(pe_done, 1'b1, "no done");
		chk(pe_ok, ok, "verdict");
	endtask
	task automatic wp(input logic h, input int n);
		wp_hold <= h;
		repeat (n) @(posedge clk);
	endtask
	////////////////////////////////////////////////////////////
	task automatic t_sw();
		chk(sw | prot, 1'b0, "on at reset");
		chk(link.wp_n, 1'b1, "wp floats low");
		pe(1'b1, 4'h1, 1'b0, 8'hFF, 1'b1);
		pe(1'b1, 4'h2, 1'b0, 8'h00, 1'b1);
		pe(1'b1, 4'h0, 1'b0, 8'hC0, 1'b1);
		pe(1'b0, 4'h1, 1'b0, 8'h00, 1'b1);
		send(OP_PROT_ON);
		chk(sw & prot, 1'b1, "enable lost");
		pe(1'b0, 4'h1, 1'b0, 8'h00, 1'b0);
		pe(1'b0, 4'h2, 1'b0, 8'h00, 1'b1);
		pe(1'b0, 4'h0, 1'b0, 8'h00, 1'b0);
		pe(1'b0, 4'h0, 1'b1, 8'h00, 1'b1);
		send(8'h55);
		chk(sw, 1'b1, "bad code acted");
		send(OP_PROT_OFF);
		chk(sw | prot, 1'b0, "disable lost");
		pe(1'b0, 4'h1, 1'b0, 8'h00, 1'b1);
		$display("end t_sw");
	endtask
	task automatic t_wp();
		wp(1'b1, 30);
		chk(wpp & prot, 1'b1, "wp late");
		chk(sw, 1'b0, "sw moved");
		pe(1'b1, 4'h2, 1'b0, 8'hFF, 1'b0);
		pe(1'b0, 4'h1, 1'b0, 8'h00, 1'b0);
		pe(1'b0, 4'h2, 1'b0, 8'h00, 1'b1);
		wp(1'b0, 30);
		chk(prot, 1'b0, "release late");
		$display("end t_wp");
	endtask
	task automatic t_wp_en();
		wp(1'b1, 30);
		send(OP_PROT_ON);
		pe(1'b0, 4'h2, 1'b0, 8'h00, 1'b1);
		pe(1'b1, 4'h2, 1'b0, 8'hFF, 1'b0);
		send(OP_PROT_OFF);
		chk(sw, 1'b1, "disable taken");
		wp(1'b0, 30);
		chk(prot, 1'b1, "kept lost");
		send(OP_PROT_OFF);
		chk(prot, 1'b0, "still on");
		wp(1'b1, 6);
		wp_hold <= 1'b0;
		repeat (30)
		begin
			@(posedge clk);
			chk(wpp, 1'b0, "glitch seen");
		end
		$display("end t_wp_en");
	endtask
	task automatic test_done();
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// Main sequence
	initial
	begin
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		t_sw();
		t_wp();
		t_wp_en();
		test_done();
	end
endmodule // sector_protection_control_tb
`default_nettype wire
